// File: bench/lic_bank_sva.sv
// Checker for the line interface register bank ports
`timescale 1ns/1ps
module lic_bank_sva
  import lic_pkg::*;
#(
  parameter int N = NUM_CH
) (
  input wire logic           mclk,
  input wire logic           rst_n,
  input wire logic           avs_read,
  input wire logic           avs_write,
  input wire logic [31:0]    avs_readdata,
  input wire logic           avs_waitrequest,
  input wire logic [1:0]     avs_response,
  input wire logic           hw_standard_select_pin,
  input wire logic [N-1:0]   fifo_near_full,
  input wire logic [N-1:0]   fifo_near_empty,
  input wire logic [N-1:0]   line_is_e1,
  input wire logic [N*8-1:0] tx_atten_fifo_depth,
  input wire logic [N-1:0]   rate_slow,
  input wire logic [N-1:0]   rate_fast,
  input wire logic [N-1:0]   chan_reset,
  input wire logic           irq
);
  logic [7:0] busy_q;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////////
  // Every channel depth must be one of the three legal sizes
  function automatic logic depth_ok(input logic [N*8-1:0] d);
    depth_ok = 1'b1;
    for (int i = 0; i < N; i++) begin
      if (!(d[8*i+:8] inside {DEPTH_128, DEPTH_64, DEPTH_32})) depth_ok = 1'b0;
    end
  endfunction : depth_ok
  // Counts consecutive cycles of channel soft reset, saturating
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) busy_q <= 8'h00;
    else if (!(|chan_reset)) busy_q <= 8'h00;
    else if (busy_q != 8'hFF) busy_q <= busy_q + 8'h01;
  end
  ////////////////////////////////////////////////////////////////////////////////
  chk_e1_pin_gate: assert property ($past(hw_standard_select_pin) |-> line_is_e1 == '0)
    else $error("line standard not forced by pin");
  chk_slow_cause: assert property ((rate_slow & ~$past(fifo_near_empty)) == '0)
    else $error("rate slow without near empty");
  chk_fast_cause: assert property ((rate_fast & ~$past(fifo_near_full)) == '0)
    else $error("rate fast without near full");
  chk_depth_legal: assert property (depth_ok(tx_atten_fifo_depth))
    else $error("illegal fifo depth");
  chk_reset_bound: assert property (busy_q <= CHANNEL_SOFT_RESET_CYC)
    else $error("channel reset too long");
  chk_rd_upper_zero: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h000000)
    else $error("upper read data not zero");
  chk_unmapped_zero: assert property (!avs_waitrequest && avs_response == 2'b11 |-> avs_readdata == 0)
    else $error("unmapped read data not zero");
  chk_bus_answer: assert property ($rose(avs_read || avs_write) |-> ##[1:4] !avs_waitrequest)
    else $error("no answer to request");
  cover property (!avs_waitrequest && avs_response == 2'b11);
  cover property ($rose(|chan_reset));
  cover property ($rose(irq));
  cover property ($rose(|rate_slow));
endmodule : lic_bank_sva

bind lic_bank lic_bank_sva #(.N(N)) lic_bank_sva_i (
  .mclk(mclk), .rst_n(rst_n), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
  .hw_standard_select_pin(hw_standard_select_pin), .fifo_near_full(fifo_near_full),
  .fifo_near_empty(fifo_near_empty), .line_is_e1(line_is_e1),
  .tx_atten_fifo_depth(tx_atten_fifo_depth), .rate_slow(rate_slow), .rate_fast(rate_fast),
  .chan_reset(chan_reset), .irq(irq)
);

// File: bench/lic_bank_tb_top.sv
// Self-checking bench for the line interface register bank
`timescale 1ns/1ps
module lic_bank_tb_top;
  import lic_pkg::*;
  logic mclk = 1'b0, rst_n = 1'b0, second_tick = 1'b0, pin = 1'b0, irq;
  logic [ADDR_W-1:0] adr;
  logic              rd, wrs, wq;
  logic [31:0]       wd, rdata;
  logic [3:0]        be;
  logic [1:0]        resp;
  logic [NUM_CH-1:0] src = '0, nfull = '0, nempty = '0, e1, en, bw, slow, fast, crst;
  logic [NUM_CH*8-1:0] depth;
  int                fails = 0, comparisons = 0;
  always #5 mclk = ~mclk;
  lic_host lic_host_i (.mclk(mclk), .avs_address(adr), .avs_read(rd), .avs_write(wrs),
    .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdata), .avs_waitrequest(wq),
    .avs_response(resp));
  lic_bank lic_bank_i (.mclk(mclk), .rst_n(rst_n), .avs_address(adr), .avs_read(rd),
    .avs_write(wrs), .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdata),
    .avs_waitrequest(wq), .avs_response(resp), .chan_irq_src(src), .second_tick(second_tick),
    .hw_standard_select_pin(pin), .fifo_near_full(nfull), .fifo_near_empty(nempty),
    .line_is_e1(e1), .tx_atten_enable(en), .tx_atten_fifo_depth(depth),
    .tx_atten_bandwidth(bw), .rate_slow(slow), .rate_fast(fast), .chan_reset(crst), .irq(irq));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      fails++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask : check
  function automatic logic [12:0] ca(input int ch, input int ofs);
    ca = 13'(((ch == 0) ? 'h7C0 + ofs : (ch - 1) * 'h40 + ofs) * 4);
  endfunction : ca
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic [1:0] r;
    lic_host_i.xfer(1'b1, a, d, q, r);
  endtask : wr
  task automatic rdc(input string n, input logic [12:0] a, input logic [7:0] e);
    logic [7:0] q;
    logic [1:0] r;
    lic_host_i.xfer(1'b0, a, 8'h00, q, r);
    check(n, {24'h0, q}, {24'h0, e});
  endtask : rdc
  task automatic conclude;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_summary(input logic [21:0] p);
    @(posedge mclk);
    src <= p;
    repeat (2) @(posedge mclk);
    rdc("sum lo", 13'h0B00, p[8:1]);
    rdc("sum mid", 13'h0C00, p[16:9]);
    rdc("sum hi", 13'h0D00, {3'b000, p[21:17]});
    rdc("sum zero", 13'h0E00, {p[0], 7'h00});
    $display("test summary done");
  endtask : t_summary
  task automatic t_timer;
    rdc("timer idle", 13'h0F00, 8'h00);
    @(posedge mclk);
    second_tick <= 1'b1;
    @(posedge mclk);
    second_tick <= 1'b0;
    rdc("timer set", 13'h0F00, 8'h01);
    wr(13'h0F00, 8'hFE);
    rdc("timer kept", 13'h0F00, 8'h01);
    check("irq masked", irq, 1'b0);
    wr(13'h1FC4, 8'h01);
    repeat (3) @(posedge mclk);
    check("irq on", irq, 1'b1);
    wr(13'h1FC0, 8'h01);
    repeat (3) @(posedge mclk);
    check("irq off", irq, 1'b0);
    wr(13'h0F00, 8'h01);
    rdc("timer clear", 13'h0F00, 8'h00);
    $display("test timer done");
  endtask : t_timer
  task automatic t_tja(input int ch);
    logic [1:0] k;
    for (int c = 0; c < 4; c++) begin
      k = 2'(c);
      wr(ca(ch, 2), {3'b111, k[1], 1'b1, k, k[0]});
      rdc("tja", ca(ch, 2), {3'b000, k[1], 1'b1, k, k[0]});
      repeat (2) @(posedge mclk);
      check("depth", depth[8*ch+:8], (k == 0) ? DEPTH_128 : (k == 1) ? DEPTH_64 : DEPTH_32);
      check("enable", en[ch], 1'b1);
      check("bandwidth", bw[ch], k[0]);
    end
    wr(ca(ch, 2), 8'h00);
    $display("test tja done");
  endtask : t_tja
  task automatic t_rate(input int ch);
    wr(ca(ch, 2), 8'h18);
    @(posedge mclk);
    nempty[ch] <= 1'b1;
    repeat (3) @(posedge mclk);
    check("slow", slow[ch], 1'b1);
    check("fast idle", fast[ch], 1'b0);
    nempty[ch] <= 1'b0;
    nfull[ch] <= 1'b1;
    repeat (3) @(posedge mclk);
    check("fast", fast[ch], 1'b1);
    wr(ca(ch, 2), 8'h08);
    repeat (3) @(posedge mclk);
    check("fast off", fast[ch], 1'b0);
    nfull[ch] <= 1'b0;
    $display("test rate done");
  endtask : t_rate
  task automatic t_std(input int ch);
    int n;
    wr(ca(ch, 1), 8'hFD);
    rdc("cfg", ca(ch, 1), 8'h01);
    repeat (2) @(posedge mclk);
    check("e1", e1[ch], 1'b1);
    pin <= 1'b1;
    repeat (3) @(posedge mclk);
    check("e1 pin", e1[ch], 1'b0);
    pin <= 1'b0;
    wr(ca(1, 2), 8'h1F);
    wr(ca(ch, 2), 8'h1F);
    wr(ca(ch, 1), 8'h03);
    rdc("cfg busy", ca(ch, 1), 8'h03);
    n = 0;
    while (crst[ch] !== 1'b0 && n < 300) begin
      @(posedge mclk);
      n++;
    end
    check("reset time", n < CHANNEL_SOFT_RESET_CYC, 1'b1);
    rdc("cfg kept", ca(ch, 1), 8'h01);
    rdc("status done", 13'h1FC0, 8'h02);
    wr(13'h1FC0, 8'h02);
    rdc("tja reset", ca(ch, 2), 8'h00);
    rdc("other tja", ca(1, 2), 8'h1F);
    $display("test std done");
  endtask : t_std
  task automatic t_unmapped;
    logic [7:0] q;
    logic [1:0] r;
    lic_host_i.xfer(1'b0, 13'h0FFC, 8'h00, q, r);
    check("resp", r, 2'b11);
    check("unmapped data", q, 8'h00);
    $display("test unmapped done");
  endtask : t_unmapped
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (5) @(posedge mclk);
    rdc("cfg default", ca(1, 1), 8'h00);
    check("depth default", depth[15:8], DEPTH_128);
    t_summary(22'h255AA5);
    t_summary(22'h1AA55A);
    t_timer();
    t_tja(0);
    t_tja(21);
    t_rate(5);
    t_std(5);
    t_std(0);
    t_unmapped();
    conclude();
  end
  // Watchdog
  initial begin
    #200us;
    fails++;
    conclude();
  end
endmodule : lic_bank_tb_top

// File: bench/lic_host.sv
// Host processor model driving the Avalon register port
`timescale 1ns/1ps
module lic_host
  import lic_pkg::*;
(
  input wire logic          mclk,
  output logic [ADDR_W-1:0] avs_address,
  output logic              avs_read,
  output logic              avs_write,
  output logic [31:0]       avs_writedata,
  output logic [3:0]        avs_byteenable,
  input wire logic [31:0]   avs_readdata,
  input wire logic          avs_waitrequest,
  input wire logic [1:0]    avs_response
);
  // Idle bus at time zero
  initial begin
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h00000000;
    avs_byteenable = 4'h0;
  end
  // One transfer, held until waitrequest is sampled low
  task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [7:0] d,
                      output logic [7:0] q, output logic [1:0] r);
    @(posedge mclk);
    avs_address <= a;
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= {24'h000000, d};
    avs_byteenable <= 4'hF;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0) @(posedge mclk);
    q = avs_readdata[7:0];
    r = avs_response;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : xfer
endmodule : lic_host

// File: logic/lic_bank.sv
// Register bank for the line interface: irq summary, timer flag, channel config
`timescale 1ns/1ps
module lic_bank
  import lic_pkg::*;
#(
  parameter int N = NUM_CH
) (
  input  wire logic                   mclk,
  input  wire logic                   rst_n,
  input  wire logic [ADDR_W-1:0]      avs_address,
  input  wire logic                   avs_read,
  input  wire logic                   avs_write,
  input  wire logic [31:0]            avs_writedata,
  input  wire logic [3:0]             avs_byteenable,
  output logic [31:0]                 avs_readdata,
  output logic                        avs_waitrequest,
  output logic [1:0]                  avs_response,
  input  wire logic [N-1:0]           chan_irq_src,
  input  wire logic                   second_tick,
  input  wire logic                   hw_standard_select_pin,
  input  wire logic [N-1:0]           fifo_near_full,
  input  wire logic [N-1:0]           fifo_near_empty,
  output logic [N-1:0]                line_is_e1,
  output logic [N-1:0]                tx_atten_enable,
  output logic [N*8-1:0]              tx_atten_fifo_depth,
  output logic [N-1:0]                tx_atten_bandwidth,
  output logic [N-1:0]                rate_slow,
  output logic [N-1:0]                rate_fast,
  output logic [N-1:0]                chan_reset,
  output logic                        irq
);
  initial begin
    if (N != NUM_CH) $error("lic_bank: N must equal NUM_CH");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset synchroniser
  logic rst_s1_q;
  logic rst_s2_q;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  logic rsn;
  assign rsn = rst_s2_q;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  logic [10:0] idx;
  logic [4:0]  blk;
  logic [5:0]  ofs;
  logic        blk_ok;
  logic [4:0]  ch;
  logic        lane0;
  assign idx    = avs_address[ADDR_W-1:2];
  assign blk    = idx[10:6];
  assign ofs    = idx[5:0];
  assign lane0  = avs_byteenable[0];
  assign blk_ok = (blk == CH0_BLOCK) || (blk <= LAST_CH_BLOCK);
  assign ch     = (blk == CH0_BLOCK) ? 5'h00 : 5'(blk + 5'h01);

  logic       is_channel_config;
  logic       is_tja;
  assign is_channel_config = blk_ok && (ofs == IDX_OFS_CHANNEL_CONFIG);
  assign is_tja  = blk_ok && (ofs == IDX_OFS_TJA);

  ////////////////////////////////////////////////////////////////////////////
  // Bus state: one wait cycle, answer on the second edge
  lic_bus_e st_q;
  logic     wr_go;
  logic     rd_go;
  always_ff @(posedge mclk or negedge rsn) begin
    if (!rsn) begin
      st_q <= LIC_IDLE;
    end else begin
      case (st_q)
        LIC_IDLE:   st_q <= (avs_read || avs_write) ? LIC_ACCESS : LIC_IDLE;
        LIC_ACCESS: st_q <= LIC_DONE;
        LIC_DONE:   st_q <= LIC_IDLE;
        default:    st_q <= LIC_IDLE;
      endcase
    end
  end
  // Writes land on the edge where waitrequest is seen low; read data is captured one edge earlier
  assign wr_go = (st_q == LIC_DONE) && avs_write;
  assign rd_go = (st_q == LIC_ACCESS) && avs_read;

  always_ff @(posedge mclk or negedge rsn) begin
    if (!rsn) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !(st_q == LIC_ACCESS && (avs_read || avs_write));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel storage
  logic [N-1:0] std_q;
  logic [7:0]   tja_q [N];
  logic [N-1:0] rst_start;
  logic [N-1:0] rst_busy;
  logic [N-1:0] rst_done;

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_ch
      lic_chan_if cif ();
      assign cif.start    = rst_start[g];
      assign rst_busy[g]  = cif.busy;
      assign rst_done[g]  = cif.done;
      lic_chan_rst #(.CYCLES(CHANNEL_SOFT_RESET_CYC)) u_rst (
        .mclk  (mclk),
        .rst_n (rsn),
        .ctl   (cif.chan)
      );
      assign rst_start[g] = wr_go && is_channel_config && lane0 && (ch == 5'(g))
                            && avs_writedata[BIT_CHANNEL_SOFT_RESET];

      // Standard select untouched by channel reset
      always_ff @(posedge mclk or negedge rsn) begin
        if (!rsn) begin
          std_q[g] <= 1'b0;
        end else if (wr_go && is_channel_config && lane0 && ch == 5'(g)) begin
          std_q[g] <= avs_writedata[BIT_STD];
        end
      end

      // Attenuator config, returns to default on channel reset
      always_ff @(posedge mclk or negedge rsn) begin
        if (!rsn) begin
          tja_q[g] <= RST_VAL;
        end else if (rst_busy[g]) begin
          tja_q[g] <= RST_VAL;
        end else if (wr_go && is_tja && lane0 && ch == 5'(g)) begin
          tja_q[g] <= avs_writedata[7:0] & TJA_MASK;
        end
      end

      // Outputs to the line side
      always_ff @(posedge mclk or negedge rsn) begin
        if (!rsn) begin
          line_is_e1[g]                <= 1'b0;
          tx_atten_enable[g]           <= 1'b0;
          tx_atten_bandwidth[g]        <= 1'b0;
          tx_atten_fifo_depth[g*8 +: 8] <= DEPTH_128;
          rate_slow[g]                 <= 1'b0;
          rate_fast[g]                 <= 1'b0;
          chan_reset[g]                <= 1'b0;
        end else begin
          line_is_e1[g]         <= !hw_standard_select_pin && std_q[g];
          tx_atten_enable[g]    <= tja_q[g][BIT_EN];
          tx_atten_bandwidth[g] <= tja_q[g][BIT_BW];
          tx_atten_fifo_depth[g*8 +: 8] <= tja_q[g][BIT_DP_HI] ? DEPTH_32 :
                                   (tja_q[g][BIT_DP_LO] ? DEPTH_64 : DEPTH_128);
          rate_slow[g] <= tja_q[g][BIT_LIMIT] && tja_q[g][BIT_EN]
                          && fifo_near_empty[g];
          rate_fast[g] <= tja_q[g][BIT_LIMIT] && tja_q[g][BIT_EN]
                          && fifo_near_full[g];
          chan_reset[g] <= rst_busy[g];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status, mask and one-second flag
  logic [IRQ_SRC_W-1:0] stat_q;
  logic [IRQ_SRC_W-1:0] mask_q;
  logic [IRQ_SRC_W-1:0] ev;
  logic [IRQ_SRC_W-1:0] w1c;
  logic                 tm_clr;
  assign ev[IRQ_TIMER]   = second_tick;
  assign ev[IRQ_RSTDONE] = |rst_done;
  assign w1c    = (wr_go && lane0 && idx == IDX_IRQ_STAT) ?
                  avs_writedata[IRQ_SRC_W-1:0] : '0;
  assign tm_clr = wr_go && lane0 && idx == IDX_TIMER && avs_writedata[BIT_TIMER];

  logic timer_flag_q;
  // Timer flag: set wins over clear
  always_ff @(posedge mclk or negedge rsn) begin
    if (!rsn) begin
      timer_flag_q <= 1'b0;
    end else begin
      timer_flag_q <= second_tick | (timer_flag_q & ~tm_clr);
    end
  end

  always_ff @(posedge mclk or negedge rsn) begin
    if (!rsn) begin
      stat_q <= '0;
    end else begin
      stat_q <= ev | (stat_q & ~w1c);
    end
  end

  always_ff @(posedge mclk or negedge rsn) begin
    if (!rsn) begin
      mask_q <= '0;
    end else if (wr_go && lane0 && idx == IDX_IRQ_MASK) begin
      mask_q <= avs_writedata[IRQ_SRC_W-1:0];
    end
  end

  always_ff @(posedge mclk or negedge rsn) begin
    if (!rsn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(stat_q & mask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux
  logic [7:0] rd_byte;
  logic       rd_ok;
  always_comb begin
    rd_byte = 8'h00;
    rd_ok   = 1'b1;
    if (idx == IDX_SUM_LO) begin
      rd_byte = chan_irq_src[8:1];
    end else if (idx == IDX_SUM_MID) begin
      rd_byte = chan_irq_src[16:9];
    end else if (idx == IDX_SUM_HI) begin
      rd_byte = {3'b000, chan_irq_src[21:17]};
    end else if (idx == IDX_SUM_ZERO) begin
      rd_byte[BIT_CH0_SUM] = chan_irq_src[0];
    end else if (idx == IDX_TIMER) begin
      rd_byte[BIT_TIMER] = timer_flag_q;
    end else if (idx == IDX_IRQ_STAT) begin
      rd_byte[IRQ_SRC_W-1:0] = stat_q;
    end else if (idx == IDX_IRQ_MASK) begin
      rd_byte[IRQ_SRC_W-1:0] = mask_q;
    end else if (is_channel_config) begin
      rd_byte[BIT_STD]   = std_q[ch];
      rd_byte[BIT_CHANNEL_SOFT_RESET] = rst_busy[ch];
    end else if (is_tja) begin
      rd_byte = tja_q[ch];
    end else begin
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rsn) begin
    if (!rsn) begin
      avs_readdata <= 32'h0000_0000;
      avs_response <= 2'b00;
    end else if (st_q == LIC_ACCESS) begin
      avs_readdata <= rd_go ? {24'h000000, rd_byte} : 32'h0000_0000;
      avs_response <= rd_ok ? 2'b00 : 2'b11;
    end
  end
endmodule : lic_bank

// File: logic/lic_chan_if.sv
// Interface carrying per-channel control from the bank to a channel reset timer
`timescale 1ns/1ps
interface lic_chan_if;
  logic start;
  logic busy;
  logic done;
  modport bank (output start, input busy, input done);
  modport chan (input start, output busy, output done);
endinterface : lic_chan_if

// File: logic/lic_chan_rst.sv
// Per-channel software reset timer
`timescale 1ns/1ps
module lic_chan_rst
  import lic_pkg::*;
#(
  parameter int CYCLES = CHANNEL_SOFT_RESET_CYC
) (
  input  wire logic  mclk,
  input  wire logic  rst_n,
  lic_chan_if.chan   ctl
);
  initial begin
    if (CYCLES < 1 || CYCLES > 255) $error("lic_chan_rst: CYCLES out of range");
  end

  logic [7:0] cnt_q;

  // Count down the reset window, finishing within the limit
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q    <= 8'h00;
      ctl.busy <= 1'b0;
      ctl.done <= 1'b0;
    end else begin
      ctl.done <= 1'b0;
      if (ctl.start) begin
        cnt_q    <= 8'(CYCLES - 1);
        ctl.busy <= 1'b1;
      end else if (ctl.busy) begin
        if (cnt_q == 8'h00) begin
          ctl.busy <= 1'b0;
          ctl.done <= 1'b1;
        end else begin
          cnt_q <= cnt_q - 8'h01;
        end
      end
    end
  end
endmodule : lic_chan_rst

// File: logic/lic_pkg.sv
// Package with register map, field positions and timing constants for the line interface bank
// Notes on behaviour
// - Bits 4..0 of the third summary register show channels 21..17 with 1 meaning an interrupt is pending.
// - Bit 7 of the fourth summary register shows channel 0 pending, bits 6..0 read zero.
// - The one-second timer flag in bit 0 sets on interval expiry, clears on a written 1, resets to 0.
// - Writing 1 to channel bit 1 resets only that channel, finishing within 1 us, then the bit clears.
// - Channel bit 0 selects T1/J1 at 0 and E1 at 1, effective only while the hardware select pin is low.
// - The line standard bit survives a per-channel software reset.
// - With attenuator bits 4 and 3 both set the outgoing rate is adjusted when the FIFO is within 2 bits of full or empty.
// - Attenuator bit 3 enables the transmit jitter attenuator, default off.
// - Attenuator bits 2..1 pick FIFO depth: 00 gives 128, 01 gives 64, 1X gives 32 bits.
// - Attenuator bit 0 picks the corner frequency, low band when 1, default 0.
// - Per-channel registers repeat every 040H from 001H for channels 1..21, channel 0 at the 7C0H block.
// - The first and second summary registers show channels 8..1 and 16..9 pending.
package lic_pkg;
  localparam int          NUM_CH        = 22;
  localparam int          ADDR_W        = 13;             // Byte address, word index 11 bits
  localparam logic [10:0] IDX_SUM_LO    = 11'h2C0;
  localparam logic [10:0] IDX_SUM_MID   = 11'h300;
  localparam logic [10:0] IDX_SUM_HI    = 11'h340;
  localparam logic [10:0] IDX_SUM_ZERO  = 11'h380;
  localparam logic [10:0] IDX_TIMER     = 11'h3C0;
  localparam logic [10:0] IDX_IRQ_STAT  = 11'h7F0;
  localparam logic [10:0] IDX_IRQ_MASK  = 11'h7F1;
  localparam logic [5:0]  IDX_OFS_CHANNEL_CONFIG  = 6'h01;
  localparam logic [5:0]  IDX_OFS_TJA   = 6'h02;
  localparam logic [4:0]  CH0_BLOCK     = 5'h1F;          // 7C0H block holds channel 0
  localparam logic [4:0]  LAST_CH_BLOCK = 5'h14;          // 500H block holds channel 21
  localparam int          BIT_TIMER     = 0;
  localparam int          BIT_CHANNEL_SOFT_RESET     = 1;
  localparam int          BIT_STD       = 0;
  localparam int          BIT_CH0_SUM   = 7;
  localparam int          BIT_LIMIT     = 4;
  localparam int          BIT_EN        = 3;
  localparam int          BIT_DP_HI     = 2;
  localparam int          BIT_DP_LO     = 1;
  localparam int          BIT_BW        = 0;
  localparam logic [7:0]  TJA_MASK      = 8'h1F;
  localparam logic [7:0]  RST_VAL       = 8'h00;
  localparam logic [7:0]  DEPTH_128     = 8'h80;
  localparam logic [7:0]  DEPTH_64      = 8'h40;
  localparam logic [7:0]  DEPTH_32      = 8'h20;
  localparam logic [7:0]  GUARD_BITS    = 8'h02;
  localparam int          CLK_MHZ       = 100;
  localparam int          CHANNEL_SOFT_RESET_NS      = 1000;
  localparam int          CHANNEL_SOFT_RESET_CYC     = (CHANNEL_SOFT_RESET_NS * CLK_MHZ) / 1000;  // Longest time rounds down
  localparam int          IRQ_SRC_W     = 2;              // Timer flag, channel reset done
  localparam int          IRQ_TIMER     = 0;
  localparam int          IRQ_RSTDONE   = 1;
  typedef enum logic [1:0] {
    LIC_IDLE   = 2'b00,
    LIC_ACCESS = 2'b01,
    LIC_DONE   = 2'b10
  } lic_bus_e;
endpackage : lic_pkg
